// ---- src/wai_pkg.sv ----
package wai_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 8;
  localparam int unsigned DIG_W  = 4;
  localparam int unsigned IDX_W  = 8;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_FLAGS  = 8'h02;
  localparam logic [IDX_W-1:0] IDX_CONFIG = 8'h53;
  localparam logic [IDX_W-1:0] IDX_MODE   = 8'h60;
  localparam logic [IDX_W-1:0] IDX_STATE  = 8'h61;

  // Flag and configuration bit positions
  localparam int unsigned BIT_POLARITY     = 7;
  localparam int unsigned FLG_LINK_BROKEN  = 6;
  localparam int unsigned FLG_POOR_QUALITY = 5;
  localparam int unsigned FLG_XFER_DONE    = 4;
  localparam int unsigned FLG_INPUT_CHANGE = 3;
  localparam int unsigned FLG_LINK_ERROR   = 2;
  localparam int unsigned FLG_WAKEUP       = 1;

  // Mode register bits
  localparam int unsigned MODE_TX_ROLE  = 0;
  localparam int unsigned MODE_SLAVE_IF = 1;

  // State register bits
  localparam int unsigned ST_POWERED  = 0;
  localparam int unsigned ST_ASSERTED = 1;
  localparam int unsigned ST_PIN_EN   = 2;

  // Masks and reset values
  localparam logic [REG_W-1:0] FLAG_IMPL_MASK = 8'h7e;
  localparam logic [REG_W-1:0] CONFIG_MASK    = 8'hfe;
  localparam logic [REG_W-1:0] MODE_MASK      = 8'h03;
  localparam logic [REG_W-1:0] TX_ONLY_MASK   = 8'h30;
  localparam logic [REG_W-1:0] FLAGS_RESET    = 8'h00;
  localparam logic [REG_W-1:0] CONFIG_RESET   = 8'h00;
  localparam logic [REG_W-1:0] MODE_RESET     = 8'h01;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum {WR_COLLECT, WR_RESP} wai_wr_e;
  typedef enum {RD_IDLE, RD_RESP} wai_rd_e;

  // Event sources from the rest of the device, same clock
  typedef struct packed {
    logic             link_broken;
    logic [REG_W-1:0] link_quality_level;
    logic [REG_W-1:0] link_warning_threshold;
    logic [REG_W-1:0] lost_packet_count;
    logic [REG_W-1:0] lost_packet_threshold;
    logic             remote_execute_done;
    logic             transmitter_config_done;
    logic             link_config_done;
    logic             receiver_config_done;
    logic [DIG_W-1:0] remote_input_value;
    logic [DIG_W-1:0] receiver_port_io_value;
    logic             powered_up;
  } wai_evt_s;

endpackage

// ---- src/wai_irq_logic.sv ----
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - Outside wakeup mode, a raised and enabled flag keeps the pin active until software writes one to it.
// - Configuration bit 7 picks pin polarity: one active high, zero active low.
// - Writing 0x7F to the flag register clears every flag together.
// - Flag bit 6 sets when the radio link breaks.
// - Flag bit 5 sets when link quality falls to or below its threshold.
// - Flag bit 4 sets when a remote execute or configuration transfer finishes.
// - Flag bit 3 sets on remote input change, or receiver port value change.
// - Flag bit 2 sets when lost packets reach or pass their threshold.
// - Flag bit 1 sets on wakeup from power down.
// - Configuration bits 6 to 2 enable the matching flags onto the pin.
// - Change detection watches the four digital lines, per role.
// - Transmitter always drives the pin; receiver only with slave interface.
// - Flags and enables are local; only this device's pin is driven.
// - With wakeup enabled, the pin simply shows the power state.
// - Poor quality and transfer done never set in the receiver role.
module wai_irq_logic
  import wai_pkg::*;
(
  input  wire logic              mclk,     // System clock, 40 MHz
  input  wire logic              rst,      // Synchronous reset, active high
  input  wire logic [ADDR_W-1:0] awaddr,   // Write address
  input  wire logic              awvalid,  // Write address valid
  output logic                   awready,  // Write address ready
  input  wire logic [DATA_W-1:0] wdata,    // Write data
  input  wire logic [3:0]        wstrb,    // Write byte strobes
  input  wire logic              wvalid,   // Write data valid
  output logic                   wready,   // Write data ready
  output logic [1:0]             bresp,    // Write response
  output logic                   bvalid,   // Write response valid
  input  wire logic              bready,   // Write response ready
  input  wire logic [ADDR_W-1:0] araddr,   // Read address
  input  wire logic              arvalid,  // Read address valid
  output logic                   arready,  // Read address ready
  output logic [DATA_W-1:0]      rdata,    // Read data
  output logic [1:0]             rresp,    // Read response
  output logic                   rvalid,   // Read data valid
  input  wire logic              rready,   // Read data ready
  input  wire wai_evt_s          evt,      // Event sources
  output logic                   irq_out,  // Interrupt pin level
  output logic                   irq_oe    // Interrupt pin drive enable
);

  // Index match on an aligned word address
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [IDX_W-1:0] idx);
    reg_hit = (addr[ADDR_W-1:2] == idx);
  endfunction

  // Rising edge of a level between two samples
  function automatic logic rose(input logic now_v, input logic was_v);
    rose = now_v & ~was_v;
  endfunction

  // Any register that answers on the bus
  function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
    reg_mapped = reg_hit(addr, IDX_FLAGS) || reg_hit(addr, IDX_CONFIG) ||
                 reg_hit(addr, IDX_MODE) || reg_hit(addr, IDX_STATE);
  endfunction

  logic [REG_W-1:0]  flags;
  logic [REG_W-1:0]  config_reg;
  logic [REG_W-1:0]  mode_reg;
  logic [REG_W-1:0]  next_flags;
  logic [REG_W-1:0]  set_bits;
  logic [REG_W-1:0]  clr_bits;

  wai_wr_e           wr_state;
  wai_rd_e           rd_state;
  logic              aw_full;
  logic              w_full;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [DATA_W-1:0] w_data_q;
  logic [3:0]        w_strb_q;
  logic              wr_fire;
  logic              wr_lane0;
  logic              wr_flags_en;
  logic              wr_config_en;
  logic              wr_mode_en;
  logic              aw_mapped;

  logic              primed;
  logic              quality_low_q;
  logic              lost_high_q;
  logic              powered_q;
  logic [DIG_W-1:0]  remote_in_q;
  logic [DIG_W-1:0]  port_io_q;
  logic [DIG_W-1:0]  remote_chg;
  logic [DIG_W-1:0]  port_chg;

  logic              role_tx;
  logic              slave_if;
  logic              quality_low;
  logic              lost_high;
  logic              xfer_done;
  logic              input_change;
  logic              assert_lvl;
  logic              asserted_q;

  assign role_tx  = mode_reg[MODE_TX_ROLE];
  assign slave_if = mode_reg[MODE_SLAVE_IF];

  // Write channel collection: address and data taken in either order
  // Ready stays low until the response is taken: one write at a time
  always_ff @(posedge mclk) begin
    if (rst) begin
      aw_full   <= 1'b0;
      aw_addr_q <= '0;
      awready   <= 1'b1;
    end else if (awvalid && awready) begin
      aw_full   <= 1'b1;
      aw_addr_q <= awaddr;
      awready   <= 1'b0;
    end else if (wr_fire) begin
      aw_full   <= 1'b0;
    end else if (bvalid && bready) begin
      awready   <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      w_full   <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
      wready   <= 1'b1;
    end else if (wvalid && wready) begin
      w_full   <= 1'b1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
      wready   <= 1'b0;
    end else if (wr_fire) begin
      w_full   <= 1'b0;
    end else if (bvalid && bready) begin
      wready   <= 1'b1;
    end
  end

  assign wr_fire = (wr_state == WR_COLLECT) && aw_full && w_full;

  // Committed write decode, lane 0 carries the 8-bit registers
  assign wr_lane0     = wr_fire && w_strb_q[0];
  assign wr_flags_en  = wr_lane0 && reg_hit(aw_addr_q, IDX_FLAGS);
  assign wr_config_en = wr_lane0 && reg_hit(aw_addr_q, IDX_CONFIG);
  assign wr_mode_en   = wr_lane0 && reg_hit(aw_addr_q, IDX_MODE);
  assign aw_mapped    = reg_mapped(aw_addr_q);

  // Write response
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_state <= WR_COLLECT;
      bvalid   <= 1'b0;
      bresp    <= RESP_OKAY;
    end else begin
      unique case (wr_state)
        WR_COLLECT: begin
          if (wr_fire) begin
            wr_state <= WR_RESP;
            bvalid   <= 1'b1;
            if (aw_mapped) begin
              bresp <= RESP_OKAY;
            end else begin
              bresp <= RESP_SLVERR;
            end
          end
        end
        WR_RESP: begin
          if (bready) begin
            wr_state <= WR_COLLECT;
            bvalid   <= 1'b0;
          end
        end
      endcase
    end
  end

  // Configuration register, bit 0 held at zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      config_reg <= CONFIG_RESET;
    end else if (wr_config_en) begin
      config_reg <= w_data_q[REG_W-1:0] & CONFIG_MASK;
    end
  end

  // Role and interface selection
  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_reg <= MODE_RESET;
    end else if (wr_mode_en) begin
      mode_reg <= w_data_q[REG_W-1:0] & MODE_MASK;
    end
  end

  // Previous samples for edge detection of compares and power state
  // First cycle after reset is ignored: reset samples need not match the lines
  always_ff @(posedge mclk) begin
    if (rst) begin
      primed        <= 1'b0;
      quality_low_q <= 1'b0;
      lost_high_q   <= 1'b0;
      powered_q     <= 1'b0;
    end else begin
      primed        <= 1'b1;
      quality_low_q <= quality_low;
      lost_high_q   <= lost_high;
      powered_q     <= evt.powered_up;
    end
  end

  // Previous samples of the four digital lines for change detection
  always_ff @(posedge mclk) begin
    if (rst) begin
      remote_in_q <= '0;
      port_io_q   <= '0;
    end else begin
      remote_in_q <= evt.remote_input_value;
      port_io_q   <= evt.receiver_port_io_value;
    end
  end

  // Per-line change detection on the four digital lines
  genvar gi;
  generate
    for (gi = 0; gi < DIG_W; gi++) begin : g_chg
      assign remote_chg[gi] = evt.remote_input_value[gi] ^ remote_in_q[gi];
      assign port_chg[gi]   = evt.receiver_port_io_value[gi] ^ port_io_q[gi];
    end
  endgenerate

  assign quality_low  = role_tx && (evt.link_quality_level <= evt.link_warning_threshold);
  assign lost_high    = evt.lost_packet_count >= evt.lost_packet_threshold;
  assign xfer_done    = role_tx && (evt.remote_execute_done || evt.transmitter_config_done ||
                                    evt.link_config_done || evt.receiver_config_done);
  assign input_change = role_tx ? |remote_chg : (slave_if && |port_chg);

  // Event collection into set bits; flags latch whatever the enables say
  always_comb begin
    set_bits                   = '0;
    set_bits[FLG_LINK_BROKEN]  = evt.link_broken;
    set_bits[FLG_POOR_QUALITY] = primed && rose(quality_low, quality_low_q);
    set_bits[FLG_XFER_DONE]    = xfer_done;
    set_bits[FLG_INPUT_CHANGE] = primed && input_change;
    set_bits[FLG_LINK_ERROR]   = primed && rose(lost_high, lost_high_q);
    set_bits[FLG_WAKEUP]       = primed && rose(evt.powered_up, powered_q);
    set_bits                   = set_bits & FLAG_IMPL_MASK;
  end

  // Write-one-to-clear, new events win over a clear in the same cycle
  always_comb begin
    clr_bits = '0;
    if (wr_flags_en) begin
      clr_bits = w_data_q[REG_W-1:0] & FLAG_IMPL_MASK;
    end
    next_flags = ((flags & ~clr_bits) | set_bits) & FLAG_IMPL_MASK;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      flags <= FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  // Pin request: power state in wakeup mode, else any enabled flag
  always_comb begin
    if (config_reg[FLG_WAKEUP]) begin
      assert_lvl = evt.powered_up;
    end else begin
      assert_lvl = |(flags & config_reg & FLAG_IMPL_MASK);
    end
  end

  // Pin level; rests inactive for the reset polarity
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_out <= 1'b1;
    end else begin
      irq_out <= config_reg[BIT_POLARITY] ? assert_lvl : ~assert_lvl;
    end
  end

  // Pin drive enable; pin is released when the role offers no pin
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_oe <= 1'b0;
    end else begin
      irq_oe <= role_tx || slave_if;
    end
  end

  // Logical pin request, shown in the state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      asserted_q <= 1'b0;
    end else begin
      asserted_q <= assert_lvl;
    end
  end

  // Read channel
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_state <= RD_IDLE;
      arready  <= 1'b1;
      rvalid   <= 1'b0;
      rdata    <= '0;
      rresp    <= RESP_OKAY;
    end else begin
      unique case (rd_state)
        RD_IDLE: begin
          if (arvalid) begin
            rd_state <= RD_RESP;
            arready  <= 1'b0;
            rvalid   <= 1'b1;
            rresp    <= RESP_OKAY;
            rdata    <= '0;
            if (reg_hit(araddr, IDX_FLAGS)) begin
              rdata[REG_W-1:0] <= flags;
            end else if (reg_hit(araddr, IDX_CONFIG)) begin
              rdata[REG_W-1:0] <= config_reg;
            end else if (reg_hit(araddr, IDX_MODE)) begin
              rdata[REG_W-1:0] <= mode_reg;
            end else if (reg_hit(araddr, IDX_STATE)) begin
              rdata[ST_POWERED]  <= evt.powered_up;
              rdata[ST_ASSERTED] <= asserted_q;
              rdata[ST_PIN_EN]   <= irq_oe;
            end else begin
              rresp <= RESP_SLVERR;
            end
          end
        end
        RD_RESP: begin
          if (rready) begin
            rd_state <= RD_IDLE;
            arready  <= 1'b1;
            rvalid   <= 1'b0;
          end
        end
      endcase
    end
  end

endmodule

// ---- verif/wai_irq_logic_checker.sv ----
`timescale 1ns/1ps
module wai_irq_logic_checker
  import wai_pkg::*;
(
  input wire logic              mclk,    // Clock
  input wire logic              rst,     // Reset
  input wire logic [ADDR_W-1:0] awaddr,  // Write address
  input wire logic              awvalid, // Address valid
  input wire logic              awready, // Address ready
  input wire logic [DATA_W-1:0] wdata,   // Write data
  input wire logic [3:0]        wstrb,   // Strobes
  input wire logic              wvalid,  // Data valid
  input wire logic              wready,  // Data ready
  input wire logic [1:0]        bresp,   // Write response
  input wire logic              bvalid,  // Response valid
  input wire logic              bready,  // Response ready
  input wire logic [DATA_W-1:0] rdata,   // Read data
  input wire logic [1:0]        rresp,   // Read response
  input wire logic              rvalid,  // Read valid
  input wire logic              rready,  // Read ready
  input wire wai_evt_s          evt,     // Events
  input wire logic              irq_out, // Pin level
  input wire logic              irq_oe   // Pin enable
);
  logic [ADDR_W-1:0] a_q;
  logic [REG_W-1:0]  d_q;
  logic [REG_W-1:0]  cfg_q;
  logic [REG_W-1:0]  mode_q;
  logic              s_q;
  logic              bv_d;
  logic              act;

  always_ff @(posedge mclk) begin
    if (awvalid && awready) a_q <= awaddr;
    if (wvalid && wready) d_q <= wdata[REG_W-1:0];
    if (wvalid && wready) s_q <= wstrb[0];
    bv_d <= bvalid;
  end

  // Shadow of config and mode, aligned with what the pin reflects
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_q  <= CONFIG_RESET;
      mode_q <= MODE_RESET;
    end else if (bvalid && !bv_d && s_q && bresp == RESP_OKAY) begin
      if (a_q[ADDR_W-1:2] == IDX_CONFIG) cfg_q <= d_q & CONFIG_MASK;
      if (a_q[ADDR_W-1:2] == IDX_MODE) mode_q <= d_q & MODE_MASK;
    end
  end

  assign act = irq_out == cfg_q[BIT_POLARITY];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_held;
    !cfg_q[FLG_WAKEUP] && act && !bvalid;
  endsequence

  AST_LINK_RAISE: assert property (cfg_q[6] && !cfg_q[1] && evt.link_broken |-> ##[1:3] act)
    else $error("link break did not raise the pin");
  AST_HOLD: assert property (s_held ##1 (!cfg_q[1] && !bvalid) |-> act)
    else $error("pin released without a clearing write");
  AST_WAKE_PIN: assert property (cfg_q[1] && !$past(rst) |-> irq_out == ($past(evt.powered_up) ~^ cfg_q[7]))
    else $error("pin does not follow power state");
  AST_NO_ENABLE: assert property (cfg_q[6:1] == 6'h00 && !$past(rst) |-> irq_out == !cfg_q[7])
    else $error("pin active with no source enabled");
  AST_PIN_AVAIL: assert property (!$past(rst) |-> irq_oe == (mode_q[0] || mode_q[1]))
    else $error("pin drive enable wrong for role");
  AST_RSV_ZERO: assert property (rvalid && rresp == RESP_OKAY |-> rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  AST_B_TIME: assert property (awvalid && awready && wvalid && wready |-> ##[1:3] bvalid)
    else $error("write response late");
endmodule

bind wai_irq_logic wai_irq_logic_checker chk_u (.mclk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
  .wvalid, .wready, .bresp, .bvalid, .bready, .rdata, .rresp, .rvalid, .rready, .evt, .irq_out, .irq_oe);

// ---- verif/wai_host_model.sv ----
`timescale 1ns/1ps
module wai_host_model (
  input  wire logic irq_out,     // Device pin level
  input  wire logic irq_oe,      // Device drive enable
  input  wire logic active_high, // Polarity the host expects
  output logic      pin,         // Resolved pin level
  output logic      irq_seen     // Host sees a request
);
  // Undriven pin rests at the board pull-up
  assign pin      = irq_oe ? irq_out : 1'b1;
  assign irq_seen = pin == active_high;
endmodule

// ---- verif/wai_irq_logic_tb.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module wai_irq_logic_tb
  import wai_pkg::*;
;
  localparam logic [ADDR_W-1:0] A_FLG = {IDX_FLAGS, 2'b00};
  localparam logic [ADDR_W-1:0] A_CFG = {IDX_CONFIG, 2'b00};
  localparam logic [ADDR_W-1:0] A_MOD = {IDX_MODE, 2'b00};
  localparam logic [ADDR_W-1:0] A_STA = {IDX_STATE, 2'b00};
  localparam logic [ADDR_W-1:0] A_UNM = 10'h3fc;
  logic mclk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, pol = 1;
  logic awready, wready, bvalid, arready, rvalid, irq_out, irq_oe, pin, seen;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata;
  logic [1:0]        bresp, rresp;
  logic [7:0]        b;
  wai_evt_s          evt, base;
  int                compares = 0, miscompares = 0, cyc = 0;

  wai_irq_logic dut_u (.mclk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .evt, .irq_out, .irq_oe);
  wai_host_model host_u (.irq_out, .irq_oe, .active_high(pol), .pin, .irq_seen(seen));

  initial forever #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic conclude();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v, input logic [1:0] er);
    @(posedge mclk);
    awaddr <= a;
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    `CHK(bresp, er)
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] ev, input logic [1:0] er);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    `CHK(rdata, {24'h000000, ev})
    `CHK(rresp, er)
  endtask

  task automatic apply();
    @(posedge mclk);
    evt <= base;
  endtask

  // One event per code, held a single cycle, then back to the base levels; code 6 flips a remote input line in the base levels, so it stays
  task automatic fire(input int i, output logic [7:0] fb);
    wai_evt_s e;
    e = base;
    case (i)
      0: e.link_broken = 1'b1;
      1: e.link_quality_level = 8'h10;
      2: e.remote_execute_done = 1'b1;
      3: e.transmitter_config_done = 1'b1;
      4: e.link_config_done = 1'b1;
      5: e.receiver_config_done = 1'b1;
      6: base.remote_input_value = base.remote_input_value ^ 4'h8;
      default: e.lost_packet_count = 8'h05;
    endcase
    if (i == 6) e = base;
    fb = (i == 0) ? 8'h40 : (i == 1) ? 8'h20 : (i < 6) ? 8'h10 : (i == 6) ? 8'h08 : 8'h04;
    @(posedge mclk);
    evt <= e;
    apply();
  endtask

  task automatic t_regs();
    rd(A_FLG, 8'h00, RESP_OKAY);
    rd(A_MOD, 8'h01, RESP_OKAY);
    wr(A_CFG, 8'hff, RESP_OKAY);
    rd(A_CFG, 8'hfe, RESP_OKAY);
    wr(A_UNM, 8'hff, RESP_SLVERR);
    rd(A_UNM, 8'h00, RESP_SLVERR);
    wr(A_FLG, 8'h7f, RESP_OKAY);
  endtask

  task automatic t_events();
    wr(A_CFG, 8'hfc, RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      fire(i, b);
      rd(A_FLG, b, RESP_OKAY);
      `CHK(seen, 1'b1)
      wr(A_FLG, 8'h81, RESP_OKAY);
      rd(A_FLG, b, RESP_OKAY);
      `CHK(seen, 1'b1)
      wr(A_FLG, b, RESP_OKAY);
      rd(A_FLG, 8'h00, RESP_OKAY);
      `CHK(seen, 1'b0)
    end
  endtask

  task automatic t_pol();
    wr(A_CFG, 8'h00, RESP_OKAY);
    fire(0, b);
    fire(7, b);
    rd(A_FLG, 8'h44, RESP_OKAY);
    `CHK(irq_out, 1'b1)
    wr(A_CFG, 8'h40, RESP_OKAY);
    repeat (2) @(posedge mclk);
    `CHK(irq_out, 1'b0)
    wr(A_CFG, 8'hc0, RESP_OKAY);
    repeat (2) @(posedge mclk);
    `CHK(irq_out, 1'b1)
    wr(A_FLG, 8'h7f, RESP_OKAY);
    rd(A_FLG, 8'h00, RESP_OKAY);
    `CHK(seen, 1'b0)
  endtask

  task automatic t_wake();
    fire(0, b);
    wr(A_CFG, 8'hc2, RESP_OKAY);
    base.powered_up = 1'b0;
    apply();
    repeat (3) @(posedge mclk);
    `CHK(seen, 1'b0)
    base.powered_up = 1'b1;
    apply();
    rd(A_FLG, 8'h42, RESP_OKAY);
    `CHK(seen, 1'b1)
    wr(A_FLG, 8'h7f, RESP_OKAY);
  endtask

  task automatic t_rx();
    wr(A_MOD, 8'h00, RESP_OKAY);
    repeat (2) @(posedge mclk);
    `CHK(irq_oe, 1'b0)
    wr(A_MOD, 8'h02, RESP_OKAY);
    for (int i = 1; i < 7; i++) fire(i, b);
    rd(A_FLG, 8'h00, RESP_OKAY);
    base.receiver_port_io_value = 4'h5;
    apply();
    rd(A_FLG, 8'h08, RESP_OKAY);
    `CHK(irq_oe, 1'b1)
    wr(A_STA, 8'h00, RESP_OKAY);
    rd(A_STA, 8'h07, RESP_OKAY);
  endtask

  initial begin
    base = '0;
    base.link_quality_level = 8'h80;
    base.link_warning_threshold = 8'h10;
    base.lost_packet_threshold = 8'h05;
    base.powered_up = 1'b1;
    evt = base;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_events();
    t_pol();
    t_wake();
    t_rx();
    conclude();
  end
endmodule
